/* dv/ccdfe_far_model.sv */
// Host serial driver and camera timing generator facing the front end
`timescale 1ns/1ps
module ccdfe_far_model (
   input wire logic core_clk,
   output logic serialClk,
   output logic serialData,
   output logic wordLoadStrobe_b,
   output logic converterClock,
   output logic referenceSamplePulse,
   output logic dataSamplePulse,
   output logic blackClampPulse,
   output logic [9:0] sampleIn
);
   logic [3:0] convCnt;
   initial begin
      convCnt = 4'h0;
      serialClk = 1'b0;
      serialData = 1'b0;
      wordLoadStrobe_b = 1'b1;
      referenceSamplePulse = 1'b1;
      dataSamplePulse = 1'b1;
      blackClampPulse = 1'b1;
      sampleIn = 10'h000;
   end
   // ==========================================
   // Converter clock, slow enough for the pin synchronisers
   always @(posedge core_clk) convCnt <= convCnt + 4'h1;
   assign converterClock = convCnt[3];
   // ==========================================
   // Serial word, 800 ns bit period, clock idle low between words
   task automatic sendWord(input logic [19:0] w, input logic longWord);
      wordLoadStrobe_b <= 1'b0;
      for (int i = longWord ? 19 : 15; i >= 0; i--) begin
         serialData <= w[i];
         repeat (4) @(posedge core_clk);
         serialClk <= 1'b1;
         repeat (4) @(posedge core_clk);
         serialClk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      wordLoadStrobe_b <= 1'b1;
      serialData <= ~serialData;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic setClamp(input logic lvl);
      blackClampPulse <= lvl;
      repeat (5) @(posedge core_clk);
   endtask
   // Pulses placed just after a converter rise so capture precedes the next one
   task automatic pixel(input logic pol, input logic [9:0] v);
      referenceSamplePulse <= ~pol;
      dataSamplePulse <= ~pol;
      do @(posedge core_clk); while (convCnt != 4'h9);
      referenceSamplePulse <= pol;
      @(posedge core_clk) referenceSamplePulse <= ~pol;
      @(posedge core_clk) dataSamplePulse <= pol;
      sampleIn <= v;
      repeat (2) @(posedge core_clk);
      dataSamplePulse <= ~pol;
   endtask
endmodule // ccdfe_far_model

/* dv/ccdfe_port_monitor.sv */
// Port checker for the sensor front end serial control block
`timescale 1ns/1ps
module ccdfe_port_monitor #(
   parameter DATA_W = 10,
   parameter LATENCY = 9
) (
   input wire core_clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [DATA_W-1:0] pixelOut,
   input wire pixelValid,
   input wire [9:0] gainCode,
   input wire signed [10:0] gainTenthDb
);
   // ==========================================
   // Bus, gain map and pipeline relations
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence accessPhase;
      psel && penable;
   endsequence
   readyHigh_a: assert property (accessPhase |-> pready)
      else $error("access phase without ready");
   errorPhase_a: assert property (pslverr |-> accessPhase)
      else $error("error flag outside access phase");
   readIdle_a: assert property (!(psel && !pwrite) |-> prdata == 32'h0)
      else $error("read data not zero outside a read");
   gainMax_a: assert property (gainCode == 10'h3ff |=> gainTenthDb == 11'sd420)
      else $error("gain code all ones not 42 dB");
   gainHigh_a: assert property (gainCode == 10'h348 |=> gainTenthDb == 11'sd340)
      else $error("high gain code not 34 dB");
   gainMedium_a: assert property (gainCode == 10'h220 |=> gainTenthDb == 11'sd200)
      else $error("medium gain code not 20 dB");
   gainUnity_a: assert property (gainCode == 10'h040 |=> gainTenthDb == 11'sd0)
      else $error("low gain code not 0 dB");
   validPulse_a: assert property (pixelValid |=> !pixelValid)
      else $error("valid longer than one cycle");
   pixelHold_a: assert property ($changed(pixelOut) |-> pixelValid)
      else $error("output word changed without valid");
endmodule // ccdfe_port_monitor

bind ccdfe_serial_control ccdfe_port_monitor #(.DATA_W(DATA_W), .LATENCY(LATENCY)) ccdfe_port_monitor_i (
   .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pixelOut(pixelOut), .pixelValid(pixelValid), .gainCode(gainCode),
   .gainTenthDb(gainTenthDb));

/* dv/ccdfe_serial_control_tb.sv */
// Self-checking bench for the sensor front end serial control block
`timescale 1ns/1ps
module ccdfe_serial_control_tb;
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, serialClk, serialData, wordLoadStrobe_b, converterClock, err;
   logic referenceSamplePulse, dataSamplePulse, blackClampPulse, pixelValid, clampActive;
   logic [9:0] sampleIn, pixelOut, gainCode;
   logic signed [10:0] gainTenthDb;
   logic [7:0] clampTarget;
   logic [9:0] gainPts [3] = '{10'h3ff, 10'h348, 10'h220};
   int gainDb [3] = '{420, 340, 200};
   int errCount = 0, checked = 0, cycles = 0;
   always #50 core_clk = ~core_clk;
   ccdfe_serial_control ccdfe_serial_control_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialClk(serialClk), .serialData(serialData), .wordLoadStrobe_b(wordLoadStrobe_b),
      .converterClock(converterClock), .referenceSamplePulse(referenceSamplePulse),
      .dataSamplePulse(dataSamplePulse), .blackClampPulse(blackClampPulse), .sampleIn(sampleIn),
      .pixelOut(pixelOut), .pixelValid(pixelValid), .clampActive(clampActive), .gainCode(gainCode),
      .gainTenthDb(gainTenthDb), .clampTarget(clampTarget));
   ccdfe_far_model ccdfe_far_model_i (.core_clk(core_clk), .serialClk(serialClk), .serialData(serialData),
      .wordLoadStrobe_b(wordLoadStrobe_b), .converterClock(converterClock),
      .referenceSamplePulse(referenceSamplePulse), .dataSamplePulse(dataSamplePulse),
      .blackClampPulse(blackClampPulse), .sampleIn(sampleIn));
   // ==========================================
   // Shared tasks
   task automatic wrapUp;
      if (errCount == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata,
         output logic slvErr);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk) penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdata = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic pixelCheck(input logic pol, input logic [9:0] v);
      int rises;
      logic prev;
      ccdfe_far_model_i.pixel(pol, v);
      rises = 0;
      prev = converterClock;
      for (int k = 0; k < 300 && pixelValid !== 1'b1; k++) begin
         @(posedge core_clk);
         if (converterClock && !prev) rises++;
         prev = converterClock;
      end
      chk("pixelValid", 32'h1, pixelValid);
      chk("latency", 32'd9, rises);
      chk("pixelOut", v, pixelOut);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("gainCode", 32'h040, gainCode);
      chk("clampTarget", 32'd130, clampTarget);
      apb(1'b0, 8'h08, 32'h0, rd, err);
      chk("clamp reset", 32'd1000, rd);
      apb(1'b0, 8'h40, 32'h0, rd, err);
      chk("unmapped error", 32'h1, err);
      for (int i = 0; i < 3; i++) begin
         ccdfe_far_model_i.sendWord({10'h000, gainPts[i]}, 1'b0);
         chk("gainCode", gainPts[i], gainCode);
         chk("gainTenthDb", gainDb[i], gainTenthDb);
      end
      ccdfe_far_model_i.sendWord(20'h01000, 1'b0);
      chk("clampTarget", 32'd2, clampTarget);
      ccdfe_far_model_i.sendWord(20'hf13ff, 1'b1);
      chk("clampTarget", 32'd242, clampTarget);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      chk("latched word", 32'h13ff, {16'h0, rd[15:0]});
      apb(1'b1, 8'h08, 32'd1000, rd, err);
      apb(1'b0, 8'h08, 32'h0, rd, err);
      chk("clamp readback", 32'd1000, rd);
      repeat (2) @(posedge core_clk);
      chk("clampTarget", 32'd130, clampTarget);
      ccdfe_far_model_i.setClamp(1'b0);
      chk("clampActive", 32'h1, clampActive);
      ccdfe_far_model_i.setClamp(1'b1);
      chk("clampActive", 32'h0, clampActive);
      pixelCheck(1'b0, 10'h15a);
      ccdfe_far_model_i.sendWord(20'h02001, 1'b0);
      chk("clampActive", 32'h1, clampActive);
      // Let any output caused by the polarity flip drain first
      repeat (200) @(posedge core_clk);
      pixelCheck(1'b1, 10'h2a5);
      ccdfe_far_model_i.sendWord(20'h02003, 1'b0);
      repeat (200) @(posedge core_clk);
      pixelCheck(1'b1, 10'h0c3);
      wrapUp;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         wrapUp;
      end
   end
endmodule // ccdfe_serial_control_tb

/* pkg/ccdfe_defines.vh */
// Constants for the sensor front end serial control block
`ifndef CCDFE_DEFINES_VH
`define CCDFE_DEFINES_VH
// ==========================================================
// Clock
`define CCDFE_CLK_MHZ 10
// ==========================================================
// APB register byte offsets
`define CCDFE_OFF_WORD 8'h00
`define CCDFE_OFF_GAIN 8'h04
`define CCDFE_OFF_CLAMP 8'h08
`define CCDFE_OFF_CONFIG 8'h0c
`define CCDFE_OFF_ENABLE 8'h10
`define CCDFE_OFF_SAMPLE 8'h14
`define CCDFE_OFF_LEVELS 8'h18
// ==========================================================
// Serial word layout: address nibble, 10-bit payload
`define CCDFE_WADDR_MSB 15
`define CCDFE_WADDR_LSB 12
`define CCDFE_WDATA_MSB 9
`define CCDFE_WADDR_GAIN 4'h0
`define CCDFE_WADDR_CLAMP 4'h1
`define CCDFE_WADDR_CONFIG 4'h2
// Config field positions
`define CCDFE_CFG_POL 0
`define CCDFE_CFG_DLY_LSB 1
`define CCDFE_CFG_DLY_MSB 2
// ==========================================================
// Reset values
`define CCDFE_RST_GAIN 10'h040
`define CCDFE_RST_CLAMP 10'h3e8
`define CCDFE_RST_CONFIG 3'h0
`define CCDFE_RST_ENABLE 1'h1
// Pin synchroniser idle levels: strobe and the three pulses sit high, clocks low
`define CCDFE_RST_PINS 6'h3a
// ==========================================================
// Timing
`define CCDFE_WORD_BITS 16
`define CCDFE_LATENCY 9
`define CCDFE_DLY01_NS 5
`define CCDFE_DLY10_NS 10
`define CCDFE_DLY11_NS 13
// ==========================================================
// Gain points in tenths of a dB, and clamp points in output codes
`define CCDFE_GPT_MAX 10'h3ff
`define CCDFE_GPT_HIGH 10'h348
`define CCDFE_GPT_MED 10'h220
`define CCDFE_GPT_LOW 10'h040
`define CCDFE_GDB_MAX 420
`define CCDFE_GDB_HIGH 340
`define CCDFE_GDB_MED 200
`define CCDFE_GDB_LOW 0
`define CCDFE_GDB_MIN (-60)
`define CCDFE_CLP_KNEE 1000
`define CCDFE_CLP_MIN 2
`define CCDFE_CLP_KNEEV 130
`define CCDFE_CLP_MAX 242
`endif

/* verilog/ccdfe_serial_control.v */
// Serial control, sample pulse polarity and fixed-latency output pipe
`timescale 1ns/1ps
`include "ccdfe_defines.vh"
module ccdfe_serial_control #(
   parameter DATA_W = 10,
   parameter LATENCY = `CCDFE_LATENCY
) (
   input wire core_clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire serialClk,
   input wire serialData,
   input wire wordLoadStrobe_b,
   input wire converterClock,
   input wire referenceSamplePulse,
   input wire dataSamplePulse,
   input wire blackClampPulse,
   input wire [DATA_W-1:0] sampleIn,
   output reg [DATA_W-1:0] pixelOut,
   output reg pixelValid,
   output reg clampActive,
   output reg [9:0] gainCode,
   output reg signed [10:0] gainTenthDb,
   output reg [7:0] clampTarget
);
   // ==========================================================
   // Derived delay counts, least times rounded up, at least one cycle
   localparam integer D1 = (`CCDFE_DLY01_NS * `CCDFE_CLK_MHZ + 999) / 1000;
   localparam integer D2 = (`CCDFE_DLY10_NS * `CCDFE_CLK_MHZ + 999) / 1000;
   localparam integer D3 = (`CCDFE_DLY11_NS * `CCDFE_CLK_MHZ + 999) / 1000;
   localparam integer DMAX = (D3 > D2) ? ((D3 > D1) ? D3 : D1) : ((D2 > D1) ? D2 : D1);

   // ==========================================================
   // Pin synchronisers
   reg [5:0] pinMeta;
   reg [5:0] pinSync;
   reg [5:0] pinLast;
   reg [DATA_W-1:0] sampleMeta;
   reg [DATA_W-1:0] sampleSync;
   // Reset to the idle pin levels, so no false strobe edge follows reset
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinMeta <= `CCDFE_RST_PINS;
         pinSync <= `CCDFE_RST_PINS;
         pinLast <= `CCDFE_RST_PINS;
         sampleMeta <= {DATA_W{1'b0}};
         sampleSync <= {DATA_W{1'b0}};
      end else begin
         pinMeta <= {blackClampPulse, dataSamplePulse, referenceSamplePulse, converterClock,
                     wordLoadStrobe_b, serialClk};
         pinSync <= pinMeta;
         pinLast <= pinSync;
         sampleMeta <= sampleIn;
         sampleSync <= sampleMeta;
      end
   end
   wire sclkRise = pinSync[0] & ~pinLast[0];
   wire strobeLow = ~pinSync[1];
   wire strobeRise = pinSync[1] & ~pinLast[1];
   wire convRise = pinSync[2] & ~pinLast[2];

   // Serial data needs its own synchroniser, same depth as the serial clock
   reg serialDataMeta;
   reg serialDataSync;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         serialDataMeta <= 1'b0;
         serialDataSync <= 1'b0;
      end else begin
         serialDataMeta <= serialData;
         serialDataSync <= serialDataMeta;
      end
   end

   // ==========================================================
   // Serial shift register and control latch
   reg [15:0] shift_reg;
   reg [15:0] word_reg;
   reg [9:0] clamp_reg;
   reg [2:0] config_reg;
   reg enable_reg;
   reg [7:0] bitCnt_reg;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= 16'h0000;
         word_reg <= 16'h0000;
         bitCnt_reg <= 8'h00;
      end else if (strobeLow && sclkRise) begin
         // Older bits fall off the top, the last sixteen remain
         shift_reg <= {shift_reg[14:0], serialDataSync};
         if (bitCnt_reg != 8'hff)
            bitCnt_reg <= bitCnt_reg + 8'h01;
      end else if (strobeRise) begin
         word_reg <= shift_reg;
         bitCnt_reg <= 8'h00;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   wire apbWr = psel & penable & pwrite;
   wire [3:0] wAddr = shift_reg[`CCDFE_WADDR_MSB:`CCDFE_WADDR_LSB];
   wire [9:0] wData = shift_reg[`CCDFE_WDATA_MSB:0];
   reg [31:0] rdMux;
   reg hit;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gainCode <= `CCDFE_RST_GAIN;
         clamp_reg <= `CCDFE_RST_CLAMP;
         config_reg <= `CCDFE_RST_CONFIG;
         enable_reg <= `CCDFE_RST_ENABLE;
      end else if (strobeRise) begin
         // Serial load wins over a bus write in the same cycle
         case (wAddr)
            `CCDFE_WADDR_GAIN: gainCode <= wData;
            `CCDFE_WADDR_CLAMP: clamp_reg <= wData;
            `CCDFE_WADDR_CONFIG: config_reg <= wData[2:0];
            default: ;
         endcase
      end else if (apbWr) begin
         case (paddr)
            `CCDFE_OFF_GAIN: gainCode <= pwdata[9:0];
            `CCDFE_OFF_CLAMP: clamp_reg <= pwdata[9:0];
            `CCDFE_OFF_CONFIG: config_reg <= pwdata[2:0];
            `CCDFE_OFF_ENABLE: enable_reg <= pwdata[0];
            default: ;
         endcase
      end
   end
   always @* begin
      rdMux = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         `CCDFE_OFF_WORD: rdMux = {8'h00, bitCnt_reg, word_reg};
         `CCDFE_OFF_GAIN: rdMux = {22'h000000, gainCode};
         `CCDFE_OFF_CLAMP: rdMux = {22'h000000, clamp_reg};
         `CCDFE_OFF_CONFIG: rdMux = {29'h00000000, config_reg};
         `CCDFE_OFF_ENABLE: rdMux = {31'h00000000, enable_reg};
         `CCDFE_OFF_SAMPLE: rdMux = {21'h000000, pixelValid, pixelOut};
         `CCDFE_OFF_LEVELS: rdMux = {5'h00, gainTenthDb, 8'h00, clampTarget};
         default: hit = 1'b0;
      endcase
   end
   assign prdata = (psel & ~pwrite) ? rdMux : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // ==========================================================
   // Gain in tenths of a dB, piecewise linear through the set points
   // Full integer width, cut to the output width on purpose below
   reg signed [31:0] gTmp;
   always @* begin
      if (gainCode >= `CCDFE_GPT_HIGH)
         gTmp = `CCDFE_GDB_HIGH + ($signed({12'h000, gainCode - `CCDFE_GPT_HIGH}) *
                (`CCDFE_GDB_MAX - `CCDFE_GDB_HIGH)) / (`CCDFE_GPT_MAX - `CCDFE_GPT_HIGH);
      else if (gainCode >= `CCDFE_GPT_MED)
         gTmp = `CCDFE_GDB_MED + ($signed({12'h000, gainCode - `CCDFE_GPT_MED}) *
                (`CCDFE_GDB_HIGH - `CCDFE_GDB_MED)) / (`CCDFE_GPT_HIGH - `CCDFE_GPT_MED);
      else if (gainCode >= `CCDFE_GPT_LOW)
         gTmp = `CCDFE_GDB_LOW + ($signed({12'h000, gainCode - `CCDFE_GPT_LOW}) *
                (`CCDFE_GDB_MED - `CCDFE_GDB_LOW)) / (`CCDFE_GPT_MED - `CCDFE_GPT_LOW);
      else
         gTmp = `CCDFE_GDB_MIN + ($signed({12'h000, gainCode}) *
                (`CCDFE_GDB_LOW - `CCDFE_GDB_MIN)) / `CCDFE_GPT_LOW;
   end

   // Clamp target: code 1000 lands on 130, full scale on 242
   reg [31:0] cTmp;
   always @* begin
      if (clamp_reg <= `CCDFE_CLP_KNEE)
         cTmp = `CCDFE_CLP_MIN + ({12'h000, clamp_reg} * (`CCDFE_CLP_KNEEV - `CCDFE_CLP_MIN)) /
                `CCDFE_CLP_KNEE;
      else
         cTmp = `CCDFE_CLP_KNEEV + ({12'h000, clamp_reg - 10'd1000} *
                (`CCDFE_CLP_MAX - `CCDFE_CLP_KNEEV)) / (1023 - `CCDFE_CLP_KNEE);
   end
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gainTenthDb <= 11'sh000;
         clampTarget <= 8'h00;
      end else begin
         gainTenthDb <= gTmp[10:0];
         clampTarget <= cTmp[7:0];
      end
   end

   // ==========================================================
   // Sample capture and fixed-latency pipe on converter clock edges
   wire activeHigh = config_reg[`CCDFE_CFG_POL];
   wire refAct = pinSync[3] ^ ~activeHigh;
   wire datAct = pinSync[4] ^ ~activeHigh;
   wire clpAct = pinSync[5] ^ ~activeHigh;
   reg datLast_reg;
   reg refSeen_reg;
   reg [DATA_W-1:0] held_reg;
   reg heldValid_reg;
   reg [DATA_W-1:0] pipe_reg [0:LATENCY-1];
   reg [LATENCY-1:0] pipeVld_reg;
   // Pipe tail is read one cycle after the converter rise that filled it
   reg convRiseD_reg;
   integer i;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         datLast_reg <= 1'b0;
         refSeen_reg <= 1'b0;
         held_reg <= {DATA_W{1'b0}};
         heldValid_reg <= 1'b0;
         pipeVld_reg <= {LATENCY{1'b0}};
         convRiseD_reg <= 1'b0;
         for (i = 0; i < LATENCY; i = i + 1)
            pipe_reg[i] <= {DATA_W{1'b0}};
      end else begin
         datLast_reg <= datAct;
         convRiseD_reg <= convRise;
         // Only a data pulse after a finished reference pulse counts
         if (refAct)
            refSeen_reg <= 1'b1;
         else if (datAct && !datLast_reg)
            refSeen_reg <= 1'b0;
         if (datAct && !datLast_reg && refSeen_reg && !refAct && enable_reg) begin
            held_reg <= sampleSync;
            heldValid_reg <= 1'b1;
         end else if (convRise) begin
            heldValid_reg <= 1'b0;
         end
         if (convRise) begin
            pipe_reg[0] <= held_reg;
            pipeVld_reg <= {pipeVld_reg[LATENCY-2:0], heldValid_reg};
            for (i = 1; i < LATENCY; i = i + 1)
               pipe_reg[i] <= pipe_reg[i-1];
         end
      end
   end

   // ==========================================================
   // Extra output delay, whole core cycles
   reg [DATA_W:0] dly_reg [0:DMAX];
   reg [1:0] dSel;
   integer dIdx;
   always @* begin
      dSel = config_reg[`CCDFE_CFG_DLY_MSB:`CCDFE_CFG_DLY_LSB];
      case (dSel)
         2'h1: dIdx = D1;
         2'h2: dIdx = D2;
         2'h3: dIdx = D3;
         default: dIdx = 0;
      endcase
   end
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i <= DMAX; i = i + 1)
            dly_reg[i] <= {(DATA_W+1){1'b0}};
         pixelOut <= {DATA_W{1'b0}};
         pixelValid <= 1'b0;
         clampActive <= 1'b0;
      end else begin
         // Ninth rise fills the tail; without the delayed strobe a tenth would be needed
         dly_reg[0] <= {pipeVld_reg[LATENCY-1] & convRiseD_reg, pipe_reg[LATENCY-1]};
         for (i = 1; i <= DMAX; i = i + 1)
            dly_reg[i] <= dly_reg[i-1];
         pixelOut <= dly_reg[dIdx][DATA_W-1:0];
         pixelValid <= dly_reg[dIdx][DATA_W];
         clampActive <= clpAct & enable_reg;
      end
   end
endmodule // ccdfe_serial_control
